/* core/chain_fetch_map.svh */
`ifndef CHAIN_FETCH_MAP_SVH
`define CHAIN_FETCH_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets on the Avalon-MM slave
// ----------------------------------------------------------------------------
`define REG_PORT_CMD      5'h00
`define REG_STATUS        5'h04
`define REG_DECODE        5'h08
`define REG_POSITION      5'h0C
`define REG_XFER_COUNT    5'h10
`define REG_DRIVE_LIMITS  5'h14
`define REG_CCB_ADDR      5'h18
`define REG_CIB_ADDR      5'h1C

// ----------------------------------------------------------------------------
// Port commands, wake-up and table layout
// ----------------------------------------------------------------------------
`define CMD_CLEAR         2'h0
`define CMD_START         2'h1
`define CMD_RESET         2'h2
`define EXT_BASELINE      8'h01
`define EXT_ALL           8'h07
`define CCB_SIGNATURE     8'h01
`define BUSY_SET          8'hFF
`define BUSY_CLEAR        8'h00
`define WUB_LEN           5'h06
`define CCB_LEN           5'h06
`define CCB_BUSY_IDX      8'h01
`define CIB_STATUS_IDX    8'h01
`define CIB_SEMA_IDX      8'h03
`define CIB_PTR_FIRST     5'h08
`define CIB_PTR_LAST      5'h0B
`define PARAM_BLOCK_FIRST        5'h08
`define PARAM_BLOCK_LAST         5'h19
`define SEMA_POSTED       8'hFF

// ----------------------------------------------------------------------------
// Parameter block decode
// ----------------------------------------------------------------------------
`define DEV_FIXED         16'h0000
`define DEV_FLOPPY        16'h0001
`define DEV_TAPE          16'h0010
`define UNIT_USED_MASK    8'h13
`define FUNC_DIAG         8'h0F
`define FUNC_READ         8'h04
`define FUNC_WRITE_BUF    8'h07
`define MOD_NO_IRQ        0
`define MOD_NO_RETRY      1
`define MOD_DELETED       2
`define STAT_DONE         8'h01
`define STAT_ERROR        8'h81

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define LIMITS_RESET      32'h0000_0000

`endif

/* core/chain_fetch_pkg.sv */
package chain_fetch_pkg;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0000,
    ST_WUB_RD   = 4'b0001,
    ST_CCB_RD   = 4'b0010,
    ST_BUSY_WR  = 4'b0011,
    ST_CIB_RD   = 4'b0100,
    ST_PARAM_BLOCK_RD  = 4'b0101,
    ST_CHECK    = 4'b0110,
    ST_EXEC     = 4'b0111,
    ST_SEMA_RD  = 4'b1000,
    ST_STAT_WR  = 4'b1001,
    ST_SEMA_WR  = 4'b1010,
    ST_HALT     = 4'b1011
  } fetch_state_t;

  typedef enum logic [1:0] {
    DEV_SEL_FIXED  = 2'b00,
    DEV_SEL_FLOPPY = 2'b01,
    DEV_SEL_TAPE   = 2'b10,
    DEV_SEL_NONE   = 2'b11
  } device_sel_t;

endpackage

/* core/control_block_chain_fetch.sv */
`timescale 1ns/1ps
`default_nettype none
`include "chain_fetch_map.svh"

module control_block_chain_fetch
  import chain_fetch_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         reset,
  input  wire logic [4:0]                   avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [31:0]                  avs_writedata,
  output logic      [31:0]                  avs_readdata,
  output logic                              avs_waitrequest,
  input  wire logic [15:0]                  port_jumper,
  output logic                              mem_read,
  output logic                              mem_write,
  output logic      [23:0]                  mem_address,
  output logic      [7:0]                   mem_writedata,
  input  wire logic [7:0]                   mem_readdata,
  input  wire logic                         mem_ack,
  output logic                              exec_start,
  input  wire logic                         exec_done,
  input  wire logic                         exec_fail,
  output chain_fetch_pkg::device_sel_t      device_sel,
  output logic      [7:0]                   unit_sel,
  output logic      [7:0]                   function_code,
  output logic      [7:0]                   test_number,
  output logic                              deleted_data,
  output logic                              no_retry,
  output logic      [15:0]                  cylinder_target,
  output logic      [31:0]                  transfer_count,
  output logic                              cmd_irq,
  output logic                              error_indicator
);
  import chain_fetch_pkg::*;

  // --------------------------------------------------------------------------
  // Address arithmetic
  // --------------------------------------------------------------------------
  function automatic logic [23:0] ptr_addr(input logic [15:0] lo, input logic [15:0] hi,
                                           input logic linear);
    logic [19:0] seg;
    seg = {hi, 4'h0} + {4'h0, lo};
    ptr_addr = linear ? {hi[7:0], lo} : {4'h0, seg};
  endfunction

  function automatic logic [23:0] add_idx(input logic [23:0] base, input logic [7:0] idx);
    add_idx = base + {16'h0000, idx};
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  fetch_state_t state;
  logic [15:0]  jumper_meta;
  logic [15:0]  jumper_sync;
  logic [4:0]   idx;
  logic [31:0]  gather;
  logic         linear_mode;
  logic [7:0]   ext_byte;
  logic         chain_valid;
  logic         held;
  logic [23:0]  ccb_base;
  logic [23:0]  cib_base;
  logic [23:0]  param_block_base;
  logic [7:0]   busy_value;
  logic [15:0]  device_word;
  logic [15:0]  modifier;
  logic [15:0]  cylinder;
  logic [7:0]   head;
  logic [7:0]   sector;
  logic [7:0]   status_value;
  logic [31:0]  limits;
  logic         bus_ack;
  logic         mem_done;
  logic         start_cmd;
  logic         clear_cmd;
  logic         reset_cmd;
  logic         range_err;
  logic         cyl_err;
  logic [23:0]  next_mem_address;
  logic         next_mem_read;
  logic         next_mem_write;
  logic [7:0]   next_mem_writedata;

  assign mem_done = (mem_read | mem_write) & mem_ack;

  // --------------------------------------------------------------------------
  // Avalon-MM slave
  // --------------------------------------------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
  assign start_cmd = avs_write & bus_ack & (avs_address == `REG_PORT_CMD)
                     & (avs_writedata[1:0] == `CMD_START);
  assign clear_cmd = avs_write & bus_ack & (avs_address == `REG_PORT_CMD)
                     & (avs_writedata[1:0] == `CMD_CLEAR);
  assign reset_cmd = avs_write & bus_ack & (avs_address == `REG_PORT_CMD)
                     & (avs_writedata[1:0] == `CMD_RESET);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (avs_read | avs_write) & ~bus_ack;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~bus_ack) begin
      case (avs_address)
        `REG_STATUS:       avs_readdata <= {14'h0000, ext_byte, state, 2'b00, cmd_irq,
                                            error_indicator, chain_valid, held};
        `REG_DECODE:       avs_readdata <= {modifier, unit_sel, function_code};
        `REG_POSITION:     avs_readdata <= {cylinder_target, head, sector};
        `REG_XFER_COUNT:   avs_readdata <= transfer_count;
        `REG_DRIVE_LIMITS: avs_readdata <= limits;
        `REG_CCB_ADDR:     avs_readdata <= {8'h00, ccb_base};
        `REG_CIB_ADDR:     avs_readdata <= {8'h00, cib_base};
        default:           avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Drive limits: [15:0] cylinders, [23:16] sectors per track, [24] double-sided.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      limits <= `LIMITS_RESET;
    end else if (avs_write & bus_ack & (avs_address == `REG_DRIVE_LIMITS)) begin
      limits <= avs_writedata;
    end
  end

  // --------------------------------------------------------------------------
  // Jumper synchroniser
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      jumper_meta <= 16'h0000;
      jumper_sync <= 16'h0000;
    end else begin
      jumper_meta <= port_jumper;
      jumper_sync <= jumper_meta;
    end
  end

  // --------------------------------------------------------------------------
  // Port-command state: held reset, interrupt, error indicator
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      held <= 1'b1;
    end else if (reset_cmd) begin
      held <= 1'b1;
    end else if (clear_cmd) begin
      held <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_irq <= 1'b0;
    end else if (reset_cmd) begin
      cmd_irq <= 1'b0;
    end else if (state == ST_SEMA_WR && mem_done && !modifier[`MOD_NO_IRQ]) begin
      cmd_irq <= 1'b1;
    end else if (clear_cmd) begin
      cmd_irq <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      error_indicator <= 1'b0;
    end else if (reset_cmd) begin
      error_indicator <= 1'b0;
    end else if (state == ST_CCB_RD && mem_done && idx == 5'h00
                 && mem_readdata != `CCB_SIGNATURE) begin
      error_indicator <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Table walk
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state        <= ST_IDLE;
      idx          <= 5'h00;
      gather       <= 32'h0000_0000;
      chain_valid  <= 1'b0;
      linear_mode  <= 1'b0;
      ext_byte     <= 8'h00;
      ccb_base     <= 24'h000000;
      cib_base     <= 24'h000000;
      param_block_base    <= 24'h000000;
      busy_value   <= `BUSY_CLEAR;
      status_value <= 8'h00;
      exec_start   <= 1'b0;
    end else if (reset_cmd) begin
      state       <= ST_IDLE;
      chain_valid <= 1'b0;
      exec_start  <= 1'b0;
    end else begin
      exec_start <= 1'b0;
      case (state)
        ST_IDLE: begin
          idx <= 5'h00;
          if (start_cmd && !held) begin
            if (!chain_valid) begin
              state <= ST_WUB_RD;
            end else begin
              busy_value <= `BUSY_SET;
              state      <= ST_BUSY_WR;
            end
          end
        end
        ST_WUB_RD: begin
          if (mem_done) begin
            if (idx == 5'h00) begin
              ext_byte    <= mem_readdata;
              linear_mode <= (mem_readdata == `EXT_ALL);
            end else if (idx >= 5'h02) begin
              gather[idx[1:0]*8 +: 8] <= mem_readdata;
            end
            idx <= (idx == 5'h00) ? 5'h02 : idx + 5'h01;
            if (idx == `WUB_LEN - 5'h01) begin
              ccb_base <= ptr_addr(gather[31:16], {mem_readdata, gather[7:0]},
                                   linear_mode);
              idx      <= 5'h00;
              state    <= ST_CCB_RD;
            end
          end
        end
        ST_CCB_RD: begin
          if (mem_done) begin
            if (idx == 5'h00 && mem_readdata != `CCB_SIGNATURE) begin
              state <= ST_HALT;
            end else begin
              if (idx >= 5'h02) begin
                gather[idx[1:0]*8 +: 8] <= mem_readdata;
              end
              idx <= (idx == 5'h00) ? 5'h02 : idx + 5'h01;
              if (idx == `CCB_LEN - 5'h01) begin
                cib_base    <= ptr_addr(gather[31:16], {mem_readdata, gather[7:0]},
                                        linear_mode);
                chain_valid <= 1'b1;
                busy_value  <= `BUSY_CLEAR;
                state       <= ST_BUSY_WR;
              end
            end
          end
        end
        ST_BUSY_WR: begin
          if (mem_done) begin
            idx   <= `CIB_PTR_FIRST;
            state <= (busy_value == `BUSY_SET) ? ST_CIB_RD : ST_IDLE;
          end
        end
        ST_CIB_RD: begin
          if (mem_done) begin
            gather[idx[1:0]*8 +: 8] <= mem_readdata;
            idx <= idx + 5'h01;
            if (idx == `CIB_PTR_LAST) begin
              param_block_base <= ptr_addr(gather[15:0], {mem_readdata, gather[23:16]},
                                    linear_mode);
              idx       <= `PARAM_BLOCK_FIRST;
              state     <= ST_PARAM_BLOCK_RD;
            end
          end
        end
        ST_PARAM_BLOCK_RD: begin
          if (mem_done) begin
            idx <= idx + 5'h01;
            if (idx == `PARAM_BLOCK_LAST) begin
              state <= ST_CHECK;
            end
          end
        end
        ST_CHECK: begin
          if (range_err) begin
            status_value <= `STAT_ERROR;
            state        <= ST_SEMA_RD;
          end else begin
            exec_start <= 1'b1;
            state      <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (exec_done) begin
            status_value <= exec_fail ? `STAT_ERROR : `STAT_DONE;
            state        <= ST_SEMA_RD;
          end
        end
        ST_SEMA_RD: begin
          if (mem_done && mem_readdata == 8'h00) begin
            state <= ST_STAT_WR;
          end
        end
        ST_STAT_WR: begin
          if (mem_done) begin
            state <= ST_SEMA_WR;
          end
        end
        ST_SEMA_WR: begin
          if (mem_done) begin
            busy_value <= `BUSY_CLEAR;
            state      <= ST_BUSY_WR;
          end
        end
        ST_HALT: begin
          state <= ST_HALT;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Parameter block capture and decode
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      device_word    <= `DEV_FIXED;
      unit_sel       <= 8'h00;
      function_code  <= 8'h00;
      modifier       <= 16'h0000;
      cylinder       <= 16'h0000;
      head           <= 8'h00;
      sector         <= 8'h00;
      transfer_count <= 32'h0000_0000;
    end else if (state == ST_PARAM_BLOCK_RD && mem_done) begin
      case (idx)
        5'h08: device_word[7:0]      <= mem_readdata;
        5'h09: device_word[15:8]     <= mem_readdata;
        5'h0A: unit_sel              <= mem_readdata & `UNIT_USED_MASK;
        5'h0B: function_code         <= mem_readdata;
        5'h0C: modifier[7:0]         <= mem_readdata;
        5'h0D: modifier[15:8]        <= mem_readdata;
        5'h0E: cylinder[7:0]         <= mem_readdata;
        5'h0F: cylinder[15:8]        <= mem_readdata;
        5'h10: head                  <= mem_readdata;
        5'h11: sector                <= mem_readdata;
        5'h16: transfer_count[7:0]   <= mem_readdata;
        5'h17: transfer_count[15:8]  <= mem_readdata;
        5'h18: transfer_count[23:16] <= mem_readdata;
        5'h19: transfer_count[31:24] <= mem_readdata;
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    case (device_word)
      `DEV_FIXED:  device_sel = DEV_SEL_FIXED;
      `DEV_FLOPPY: device_sel = DEV_SEL_FLOPPY;
      `DEV_TAPE:   device_sel = DEV_SEL_TAPE;
      default:     device_sel = DEV_SEL_NONE;
    endcase
  end

  assign test_number  = (function_code == `FUNC_DIAG) ? modifier[15:8] : 8'h00;
  assign deleted_data = modifier[`MOD_DELETED] & (function_code >= `FUNC_READ)
                        & (function_code <= `FUNC_WRITE_BUF);
  assign no_retry     = modifier[`MOD_NO_RETRY];

  // --------------------------------------------------------------------------
  // Range checks against the initialised drive
  // --------------------------------------------------------------------------
  always_comb begin
    cyl_err   = (cylinder >= limits[15:0]);
    range_err = cyl_err;
    if (device_sel == DEV_SEL_FLOPPY) begin
      range_err = range_err | (sector == 8'h00) | (sector > limits[23:16])
                  | (head > {7'h00, limits[24]});
    end else if (device_sel == DEV_SEL_FIXED) begin
      range_err = range_err | (sector >= limits[23:16]);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cylinder_target <= 16'h0000;
    end else if (state == ST_CHECK) begin
      cylinder_target <= cyl_err ? 16'h0000 : cylinder;
    end
  end

  // --------------------------------------------------------------------------
  // Memory master requests
  // --------------------------------------------------------------------------
  always_comb begin
    next_mem_read      = 1'b0;
    next_mem_write     = 1'b0;
    next_mem_address   = 24'h000000;
    next_mem_writedata = 8'h00;
    case (state)
      ST_WUB_RD: begin
        next_mem_read    = 1'b1;
        next_mem_address = add_idx({4'h0, jumper_sync, 4'h0}, {3'b000, idx});
      end
      ST_CCB_RD: begin
        next_mem_read    = 1'b1;
        next_mem_address = add_idx(ccb_base, {3'b000, idx});
      end
      ST_BUSY_WR: begin
        next_mem_write     = 1'b1;
        next_mem_address   = add_idx(ccb_base, `CCB_BUSY_IDX);
        next_mem_writedata = busy_value;
      end
      ST_CIB_RD: begin
        next_mem_read    = 1'b1;
        next_mem_address = add_idx(cib_base, {3'b000, idx});
      end
      ST_PARAM_BLOCK_RD: begin
        next_mem_read    = 1'b1;
        next_mem_address = add_idx(param_block_base, {3'b000, idx});
      end
      ST_SEMA_RD: begin
        next_mem_read    = 1'b1;
        next_mem_address = add_idx(cib_base, `CIB_SEMA_IDX);
      end
      ST_STAT_WR: begin
        next_mem_write     = 1'b1;
        next_mem_address   = add_idx(cib_base, `CIB_STATUS_IDX);
        next_mem_writedata = status_value;
      end
      ST_SEMA_WR: begin
        next_mem_write     = 1'b1;
        next_mem_address   = add_idx(cib_base, `CIB_SEMA_IDX);
        next_mem_writedata = `SEMA_POSTED;
      end
      default: begin
      end
    endcase
  end

  // A request drops for one cycle after each acknowledge so the next address
  // is presented only once the walk has moved on.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mem_read      <= 1'b0;
      mem_write     <= 1'b0;
      mem_address   <= 24'h000000;
      mem_writedata <= 8'h00;
    end else begin
      mem_read      <= next_mem_read & ~mem_done & ~reset_cmd;
      mem_write     <= next_mem_write & ~mem_done & ~reset_cmd;
      mem_address   <= next_mem_address;
      mem_writedata <= next_mem_writedata;
    end
  end

endmodule // control_block_chain_fetch

`default_nettype wire

/* sim/chain_fetch_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module chain_fetch_sva (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        mem_read,
  input wire logic        mem_write,
  input wire logic [23:0] mem_address,
  input wire logic        mem_ack,
  input wire logic        exec_start,
  input wire logic        error_indicator,
  input wire logic [7:0]  function_code,
  input wire logic [7:0]  test_number,
  input wire logic [7:0]  unit_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait too long");
  a_mem_hold: assert property (mem_read && !mem_ack |=> mem_read && $stable(mem_address))
    else $error("memory read dropped early");
  a_mem_gap: assert property ((mem_read || mem_write) && mem_ack |=> !mem_read && !mem_write)
    else $error("memory request not released");
  a_start_once: assert property (exec_start |=> !exec_start)
    else $error("start pulse too long");
  a_err_stays: assert property (error_indicator && !avs_write |=> error_indicator)
    else $error("error indicator lost");
  a_err_quiet: assert property (error_indicator |-> !mem_write)
    else $error("write after halt");
  a_diag_only: assert property (test_number != 8'h00 |-> function_code == 8'h0F)
    else $error("test number outside diagnostic");
  a_unit_mask: assert property ((unit_sel & 8'hEC) == 8'h00)
    else $error("reserved unit bits used");
  cover property (exec_start);
  cover property ($rose(error_indicator));
  cover property (mem_write && mem_ack);
endmodule // chain_fetch_sva
`default_nettype wire

/* sim/chain_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module chain_mem_model (
  input wire logic        clk,
  input wire logic        mem_read,
  input wire logic        mem_write,
  input wire logic [23:0] mem_address,
  input wire logic [7:0]  mem_writedata,
  output logic     [7:0]  mem_readdata,
  output logic            mem_ack
);
  // The bench edits the tables between tests and sets busy before each command start and before each wake-up.
  logic [7:0] m [0:1023];
  logic [1:0] wt = 2'h0;
  initial mem_ack = 1'b0;
  initial mem_readdata = 8'h00;
  // Wait states follow the low address bits; idle read data keeps changing.
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_readdata <= ~mem_readdata;
    if ((mem_read || mem_write) && !mem_ack) begin
      if (wt != mem_address[1:0]) wt <= wt + 2'h1;
      else begin
        wt <= 2'h0;
        mem_ack <= 1'b1;
        mem_readdata <= m[mem_address[9:0]];
        if (mem_write) m[mem_address[9:0]] <= mem_writedata;
      end
    end
  end
endmodule // chain_mem_model
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "chain_fetch_map.svh"
module tb_top;
  import chain_fetch_pkg::*;
  logic clk = 0, reset = 1, avs_read = 0, avs_write = 0, exec_done = 0;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q, transfer_count;
  logic avs_waitrequest, mem_read, mem_write, mem_ack, exec_start, deleted_data, no_retry;
  logic cmd_irq, error_indicator;
  logic [23:0] mem_address;
  logic [7:0] mem_writedata, mem_readdata, unit_sel, function_code, test_number;
  logic [15:0] cylinder_target;
  device_sel_t device_sel;
  int mismatches = 0, checks = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) exec_done <= exec_start;
  control_block_chain_fetch DUT (.clk, .reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .port_jumper(16'h0010), .mem_read,
    .mem_write, .mem_address, .mem_writedata, .mem_readdata, .mem_ack, .exec_start, .exec_done,
    .exec_fail(1'b0), .device_sel, .unit_sel, .function_code, .test_number, .deleted_data,
    .no_retry, .cylinder_target, .transfer_count, .cmd_irq, .error_indicator);
  chain_mem_model mem (.clk, .mem_read, .mem_write, .mem_address, .mem_writedata,
    .mem_readdata, .mem_ack);
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task w16(input int a, input logic [15:0] v);
    mem.m[a] = v[7:0];
    mem.m[a+1] = v[15:8];
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task t_wake;
    bus(1, `REG_PORT_CMD, 0);
    bus(1, `REG_PORT_CMD, 1);
    wait (mem.m['h205] === 8'h00);
    bus(0, `REG_CCB_ADDR, 0);
    chk(q, 32'h204);
    bus(0, `REG_CIB_ADDR, 0);
    chk(q, 32'h300);
    bus(0, `REG_PORT_CMD, 0);
    chk(q, 32'h0);
    $display("wake test done");
  endtask
  task t_cmd;
    mem.m['h205] = 8'hFF;
    bus(1, `REG_DRIVE_LIMITS, 32'h010F0050);
    bus(1, `REG_PORT_CMD, 1);
    wait (mem.m['h205] === 8'h00);
    chk(mem.m['h301], 8'h01);
    chk(mem.m['h303], 8'hFF);
    chk(unit_sel, 8'h13);
    chk(test_number, 8'h05);
    chk({deleted_data, no_retry, cmd_irq}, 3'b011);
    chk(device_sel, DEV_SEL_FLOPPY);
    chk(transfer_count, 32'h12345678);
    chk(cylinder_target, 16'h0012);
    $display("command test done");
  endtask
  task t_range;
    mem.m['h34E] = 8'h60;
    mem.m['h205] = 8'hFF;
    mem.m['h303] = 8'h00;
    bus(1, `REG_PORT_CMD, 1);
    wait (mem.m['h205] === 8'h00);
    chk(mem.m['h301], 8'h81);
    chk(cylinder_target, 16'h0000);
    $display("range test done");
  endtask
  task t_lin;
    bus(1, `REG_PORT_CMD, 2);
    mem.m['h100] = 8'h07;
    w16('h102, 16'h0180);
    w16('h104, 16'h0002);
    w16('h180, 16'hFF01);
    w16('h182, 16'h0300);
    w16('h184, 16'h0001);
    bus(1, `REG_PORT_CMD, 0);
    bus(1, `REG_PORT_CMD, 1);
    wait (mem.m['h181] === 8'h00);
    bus(0, `REG_CCB_ADDR, 0);
    chk(q, 32'h0002_0180);
    bus(0, `REG_CIB_ADDR, 0);
    chk(q, 32'h0001_0300);
    bus(0, `REG_STATUS, 0);
    chk(q, 32'h0000_1C02);
    $display("linear test done");
  endtask
  task t_bad;
    bus(1, `REG_PORT_CMD, 2);
    mem.m['h204] = 8'h02;
    mem.m['h205] = 8'hFF;
    bus(1, `REG_PORT_CMD, 0);
    bus(1, `REG_PORT_CMD, 1);
    for (int i = 0; i < 300 && error_indicator !== 1'b1; i++) @(posedge clk);
    chk({error_indicator, cmd_irq}, 2'b10);
    chk(mem.m['h205], 8'hFF);
    $display("signature test done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    foreach (mem.m[i]) mem.m[i] = 8'h00;
    w16('h100, 16'hAA01); w16('h102, 16'h0004); w16('h104, 16'h0020);
    w16('h204, 16'hFF01); w16('h208, 16'h0030); w16('h308, 16'h0040); w16('h30A, 16'h0030);
    w16('h348, 16'h0001); w16('h34A, 16'h0FFF); w16('h34C, 16'h0506); w16('h34E, 16'h0012);
    w16('h350, 16'h0101); w16('h356, 16'h5678); w16('h358, 16'h1234);
    t_wake;
    t_cmd;
    t_range;
    t_bad;
    t_lin;
    give_verdict;
  end
  initial begin
    #500000;
    mismatches++;
    give_verdict;
  end
endmodule // tb_top
bind control_block_chain_fetch chain_fetch_sva SVA (.clk, .reset, .avs_read, .avs_write,
  .avs_waitrequest, .mem_read, .mem_write, .mem_address, .mem_ack, .exec_start,
  .error_indicator, .function_code, .test_number, .unit_sel);
`default_nettype wire
